// >>> design/fscr_config_regs.sv
`default_nettype none
// ****************************************************************
// configuration register bank of the fractional-N synthesizer
// ****************************************************************
// How it works
// - seed words 0x28/0x29 load the engine start state
// - numerator halves at 0x2A/0x2B, reset zero
// - output A drive level bits 13-8, reset 0x1F
// - output B drive level bits 5-0, reset 0x1F
// - bit 7 powers B down, bit 6 A
// - bit 5 engine reset low, order bits 2-0
// - source selects for outputs A and B
// - ignore sync pins unless phase sync enabled
// - lock kind bit picks detection mode, reset one
// - calibration lock after calibration plus delay countdown
// - combined lock also needs tuning voltage in range
// - lock delay counts detector cycles, reset 0x9C4
// - reset delay upper half at 0x45, reset zero
// - reset delay lower half at 0x46, reset 0xC350
module fscr_config_regs
   import fscr_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            resetn,
   input  wire fscr_bus_req_t   bus_req,
   output var  logic [15:0]     rd_data,
   input  wire logic            cal_done_pin,
   input  wire logic            vtune_ok_pin,
   input  wire logic            pd_cycle_tick,
   input  wire logic            sync_pin,
   input  wire logic            sysref_pin,
   output var  fscr_frac_cfg_t  frac_cfg,
   output var  fscr_out_cfg_t   out_a_cfg,
   output var  fscr_out_cfg_t   out_b_cfg,
   output var  logic [31:0]     frac_reset_delay_count,
   output var  logic            phase_sync_enable,
   output var  logic            sync_out,
   output var  logic            sysref_out,
   output var  logic            lock_indicator,
   output var  logic            irq
);

   // ****************************************************************
   // storage
   // ****************************************************************
   logic [15:0]      regs [NREG];
   logic [NREG-1:0]  wr_hit;
   logic [15:0]      rd_mux;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] next_irq_status;
   logic [IRQ_W-1:0] irq_events;
   logic             lock_prev;
   logic [1:0]       pin_evt;
   logic [1:0]       pin_level;

   // ****************************************************************
   // write decode
   // ****************************************************************
   // one hit per stored register; unmapped writes hit nothing
   for (genvar i = 0; i < NREG; i++) begin : g_hit
      assign wr_hit[i] = bus_req.wr && (bus_req.addr == REG_ADDR[i]);
   end

   wire logic clr_hit = bus_req.wr && (bus_req.addr == ADDR_IRQ_CLEAR);
   wire logic [IRQ_W-1:0] clr_bits =
      clr_hit ? bus_req.wdata[IRQ_W-1:0] : '0;

   // masked store keeps reserved bits at zero whatever is written
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NREG; i++) begin
            regs[i] <= REG_RESET[i];
         end
      end else begin
         for (int i = 0; i < NREG; i++) begin
            if (wr_hit[i]) begin
               regs[i] <= bus_req.wdata & REG_MASK[i];
            end
         end
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   // status reads live; clear register is write-only and reads zero
   always_comb begin
      rd_mux = '0;
      for (int i = 0; i < NREG; i++) begin
         if (bus_req.addr == REG_ADDR[i]) begin
            rd_mux = regs[i];
         end
      end
      if (bus_req.addr == ADDR_IRQ_STATUS) begin
         rd_mux = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
      end
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= bus_req.rd ? rd_mux : '0;
      end
   end

   // ****************************************************************
   // configuration fields
   // ****************************************************************
   // the engine takes seed as its start state while held in reset
   assign frac_cfg.seed      = {regs[IX_SEED_HI], regs[IX_SEED_LO]};
   assign frac_cfg.numerator = {regs[IX_NUM_HI], regs[IX_NUM_LO]};
   assign frac_cfg.reset_n   = regs[IX_PWR_ENG][POS_ENG_RSTN];
   assign frac_cfg.order     = regs[IX_PWR_ENG][POS_ORDER +: 3];

   // output A: level in the shared control word, source one word up
   assign out_a_cfg.drive_level   = regs[IX_PWR_ENG][POS_A_LEVEL +: 6];
   assign out_a_cfg.power_down    = regs[IX_PWR_ENG][POS_A_PD];
   assign out_a_cfg.source_select = regs[IX_A_SRC_B][POS_A_SRC +: 2];

   // output B: level shares a word with the A source select
   assign out_b_cfg.drive_level   = regs[IX_A_SRC_B][POS_B_LEVEL +: 6];
   assign out_b_cfg.power_down    = regs[IX_PWR_ENG][POS_B_PD];
   assign out_b_cfg.source_select = regs[IX_B_SRC][POS_B_SRC +: 2];

   // the delay count only matters while phase sync is in use
   assign frac_reset_delay_count =
      {regs[IX_FRST_HI], regs[IX_FRST_LO]};
   assign phase_sync_enable = regs[IX_SYNC][POS_PHASE_SYNC];

   wire logic ignore_sync_inputs = regs[IX_PIN_GATE][POS_PIN_IGNORE];
   wire logic lock_indicator_kind = regs[IX_LD_KIND][POS_LD_KIND];
   wire logic [15:0] lock_indicator_delay = regs[IX_LD_DELAY];

   // pins are dropped only while phase sync is off
   wire logic gate_block = ignore_sync_inputs && !phase_sync_enable;

   // ****************************************************************
   // pin gating and lock indication
   // ****************************************************************
   fscr_pin_gate #(
      .N        (2)
   ) u_pin_gate (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .pin      ({sysref_pin, sync_pin}),
      .block    (gate_block),
      .pin_out  (pin_level),
      .rise_evt (pin_evt)
   );

   assign sync_out   = pin_level[0];
   assign sysref_out = pin_level[1];

   fscr_lock_detect #(
      .CNT_W          (16)
   ) u_lock_detect (
      .sys_clk        (sys_clk),
      .resetn         (resetn),
      .cal_done_pin   (cal_done_pin),
      .vtune_ok_pin   (vtune_ok_pin),
      .pd_cycle_tick  (pd_cycle_tick),
      .lock_kind      (lock_indicator_kind),
      .lock_delay     (lock_indicator_delay),
      .lock_indicator (lock_indicator)
   );

   // ****************************************************************
   // interrupts
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lock_prev <= 1'b0;
      end else begin
         lock_prev <= lock_indicator;
      end
   end

   // event order follows the status bit positions
   assign irq_events[IRQ_LOCK_RISE] = lock_indicator && !lock_prev;
   assign irq_events[IRQ_LOCK_FALL] = !lock_indicator && lock_prev;
   assign irq_events[IRQ_SYNC]      = pin_evt[0];
   assign irq_events[IRQ_SYSREF]    = pin_evt[1];

   // set beats clear so an event in the clearing cycle survives
   assign next_irq_status = (irq_status & ~clr_bits) | irq_events;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   // level output, high while an enabled status bit is set
   assign irq = |(irq_status & regs[IX_IRQ_EN][IRQ_W-1:0]);

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   seed_words_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_SEED_HI
      |=> frac_cfg.seed[31:16] == $past(bus_req.wdata))
      else $error("seed upper half not taken");

   numer_words_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_NUM_LO
      |=> frac_cfg.numerator[15:0] == $past(bus_req.wdata))
      else $error("numerator lower half not taken");

   a_level_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_PWR_ENG
      |=> out_a_cfg.drive_level == $past(bus_req.wdata[13:8]))
      else $error("output A level wrong");

   b_level_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_A_SRC_B
      |=> out_b_cfg.drive_level == $past(bus_req.wdata[5:0])
          && out_a_cfg.source_select == $past(bus_req.wdata[12:11]))
      else $error("output B level or A source wrong");

   power_down_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_PWR_ENG
      |=> out_b_cfg.power_down == $past(bus_req.wdata[7])
          && out_a_cfg.power_down == $past(bus_req.wdata[6]))
      else $error("power down bits swapped or lost");

   engine_ctl_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_PWR_ENG
      |=> frac_cfg.reset_n == $past(bus_req.wdata[5])
          && frac_cfg.order == $past(bus_req.wdata[2:0]))
      else $error("engine reset or order wrong");

   b_source_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_B_SRC
      |=> out_b_cfg.source_select == $past(bus_req.wdata[1:0]))
      else $error("output B source wrong");

   pin_gate_a : assert property (
      gate_block ##1 gate_block |-> !sync_out && !sysref_out)
      else $error("ignored pins still pass");

   lock_kind_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_LD_KIND
      |=> lock_indicator_kind == $past(bus_req.wdata[0]))
      else $error("lock kind bit not taken");

   reset_cnt_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_FRST_HI
      |=> frac_reset_delay_count[31:16] == $past(bus_req.wdata))
      else $error("reset delay upper half not taken");

   reserved_zero_a : assert property (
      bus_req.rd && bus_req.addr == ADDR_PWR_ENG
      |=> rd_data[15:14] == 2'h0 && rd_data[4:3] == 2'h0)
      else $error("reserved bits read non-zero");

   read_back_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_LD_DELAY
      ##1 bus_req.rd && bus_req.addr == ADDR_LD_DELAY
      |=> rd_data == $past(bus_req.wdata, 2))
      else $error("lock delay read-back mismatch");

   set_wins_a : assert property (
      irq_events[IRQ_SYNC] && clr_bits[IRQ_SYNC]
      |=> irq_status[IRQ_SYNC])
      else $error("event lost under clear");

   // remaining halves, pin gate controls and bus behaviour
   seed_low_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_SEED_LO
      |=> frac_cfg.seed[15:0] == $past(bus_req.wdata))
      else $error("seed lower half not taken");

   numer_high_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_NUM_HI
      |=> frac_cfg.numerator[31:16] == $past(bus_req.wdata))
      else $error("numerator upper half not taken");

   reset_low_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_FRST_LO
      |=> frac_reset_delay_count[15:0] == $past(bus_req.wdata))
      else $error("reset delay lower half not taken");

   lock_delay_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_LD_DELAY
      |=> lock_indicator_delay == $past(bus_req.wdata))
      else $error("lock delay not taken");

   pin_ignore_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_PIN_GATE
      |=> ignore_sync_inputs == $past(bus_req.wdata[15]))
      else $error("pin ignore bit not taken");

   sync_enable_a : assert property (
      bus_req.wr && bus_req.addr == ADDR_SYNC_CTRL
      |=> phase_sync_enable == $past(bus_req.wdata[0]))
      else $error("phase sync enable not taken");

   src_b_clean_a : assert property (
      bus_req.rd && bus_req.addr == ADDR_A_SRC_B
      |=> rd_data[15:13] == 3'h0 && rd_data[10:6] == 5'h00)
      else $error("source word reserved bits set");

   b_src_read_a : assert property (
      bus_req.rd && bus_req.addr == ADDR_B_SRC
      |=> rd_data[15:2] == 14'h0000)
      else $error("output B source word reserved bits set");

   rd_idle_a : assert property (
      !bus_req.rd |=> rd_data == 16'h0000)
      else $error("read data outlived its cycle");

   clear_works_a : assert property (
      clr_hit && irq_events == '0
      |=> (irq_status & $past(clr_bits)) == '0)
      else $error("cleared status bit survived");

   status_sticky_a : assert property (
      !clr_hit |=> (irq_status & $past(irq_status)) == $past(irq_status))
      else $error("status bit dropped without a clear");

   set_clear_c : cover property (
      irq_events[IRQ_SYNC] && clr_bits[IRQ_SYNC]);

   lock_irq_c : cover property (
      irq_events[IRQ_LOCK_RISE] ##1 irq);

   gated_sync_c : cover property (
      !gate_block ##[1:8] sync_out);

   clear_c : cover property (
      irq_status != '0 ##1 clr_hit ##1 irq_status == '0);

endmodule // fscr_config_regs
`default_nettype wire

// >>> common/fscr_pkg.sv
`default_nettype none
// ****************************************************************
// constants and carriers of the synthesizer configuration bank
// ****************************************************************
package fscr_pkg;

   // bus geometry: word-wide registers at their printed offsets
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [6:0] ADDR_SEED_HI    = 7'h28;
   localparam logic [6:0] ADDR_SEED_LO    = 7'h29;
   localparam logic [6:0] ADDR_NUM_HI     = 7'h2A;
   localparam logic [6:0] ADDR_NUM_LO     = 7'h2B;
   localparam logic [6:0] ADDR_PWR_ENG    = 7'h2C;
   localparam logic [6:0] ADDR_A_SRC_B    = 7'h2D;
   localparam logic [6:0] ADDR_B_SRC      = 7'h2E;
   localparam logic [6:0] ADDR_PIN_GATE   = 7'h3A;
   localparam logic [6:0] ADDR_LD_KIND    = 7'h3B;
   localparam logic [6:0] ADDR_LD_DELAY   = 7'h3C;
   localparam logic [6:0] ADDR_FRST_HI    = 7'h45;
   localparam logic [6:0] ADDR_FRST_LO    = 7'h46;
   localparam logic [6:0] ADDR_SYNC_CTRL  = 7'h50;
   localparam logic [6:0] ADDR_IRQ_STATUS = 7'h51;
   localparam logic [6:0] ADDR_IRQ_ENABLE = 7'h52;
   localparam logic [6:0] ADDR_IRQ_CLEAR  = 7'h53;

   // storage index of each read/write register
   localparam int NREG        = 14;
   localparam int IX_SEED_HI  = 0;
   localparam int IX_SEED_LO  = 1;
   localparam int IX_NUM_HI   = 2;
   localparam int IX_NUM_LO   = 3;
   localparam int IX_PWR_ENG  = 4;
   localparam int IX_A_SRC_B  = 5;
   localparam int IX_B_SRC    = 6;
   localparam int IX_PIN_GATE = 7;
   localparam int IX_LD_KIND  = 8;
   localparam int IX_LD_DELAY = 9;
   localparam int IX_FRST_HI  = 10;
   localparam int IX_FRST_LO  = 11;
   localparam int IX_SYNC     = 12;
   localparam int IX_IRQ_EN   = 13;

   localparam logic [6:0] REG_ADDR [NREG] = '{
      ADDR_SEED_HI, ADDR_SEED_LO, ADDR_NUM_HI, ADDR_NUM_LO, ADDR_PWR_ENG,
      ADDR_A_SRC_B, ADDR_B_SRC, ADDR_PIN_GATE, ADDR_LD_KIND, ADDR_LD_DELAY,
      ADDR_FRST_HI, ADDR_FRST_LO, ADDR_SYNC_CTRL, ADDR_IRQ_ENABLE};

   // writable bits; everything else is reserved and reads zero
   localparam logic [15:0] REG_MASK [NREG] = '{
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h3FE7,
      16'h183F, 16'h0003, 16'h8000, 16'h0001, 16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'h0001, 16'h000F};

   // values after reset
   localparam logic [15:0] REG_RESET [NREG] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1FA3,
      16'h001F, 16'h0001, 16'h8000, 16'h0001, 16'h09C4,
      16'h0000, 16'hC350, 16'h0000, 16'h0000};

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int POS_A_LEVEL    = 8;
   localparam int POS_B_PD       = 7;
   localparam int POS_A_PD       = 6;
   localparam int POS_ENG_RSTN   = 5;
   localparam int POS_ORDER      = 0;
   localparam int POS_A_SRC      = 11;
   localparam int POS_B_LEVEL    = 0;
   localparam int POS_B_SRC      = 0;
   localparam int POS_PIN_IGNORE = 15;
   localparam int POS_LD_KIND    = 0;
   localparam int POS_PHASE_SYNC = 0;

   // interrupt status bits
   localparam int IRQ_W          = 4;
   localparam int IRQ_LOCK_RISE  = 0;
   localparam int IRQ_LOCK_FALL  = 1;
   localparam int IRQ_SYNC       = 2;
   localparam int IRQ_SYSREF     = 3;

   // ****************************************************************
   // carriers and states
   // ****************************************************************
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } fscr_bus_req_t;

   typedef struct packed {
      logic       power_down;
      logic [1:0] source_select;
      logic [5:0] drive_level;
   } fscr_out_cfg_t;

   typedef struct packed {
      logic        reset_n;
      logic [2:0]  order;
      logic [31:0] seed;
      logic [31:0] numerator;
   } fscr_frac_cfg_t;

   typedef enum logic [1:0] {
      LD_WAIT_CAL,
      LD_COUNT,
      LD_LOCKED
   } fscr_lock_state_t;

endpackage : fscr_pkg
`default_nettype wire

// >>> design/fscr_pin_gate.sv
`default_nettype none
// ****************************************************************
// synchroniser and gate for the sync-type input pins
// ****************************************************************
module fscr_pin_gate
   import fscr_pkg::*;
#(
   parameter int N = 2
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic [N-1:0] pin,
   input  wire logic         block,
   output var  logic [N-1:0] pin_out,
   output var  logic [N-1:0] rise_evt
);

   if (N < 1) begin : g_chk
      $error("fscr_pin_gate needs at least one pin");
   end

   logic [N-1:0] meta;
   logic [N-1:0] sync;
   logic [N-1:0] sync_d;

   // two flops before any logic; meta feeds only sync
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta   <= '0;
         sync   <= '0;
         sync_d <= '0;
      end else begin
         meta   <= pin;
         sync   <= meta;
         sync_d <= sync;
      end
   end

   // a blocked pin is held low and raises no event
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_out  <= '0;
         rise_evt <= '0;
      end else begin
         pin_out  <= block ? '0 : sync;
         rise_evt <= block ? '0 : (sync & ~sync_d);
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   blocked_quiet_a : assert property (block |=> (pin_out == '0))
      else $error("gated pin leaked through");

endmodule // fscr_pin_gate
`default_nettype wire

// >>> design/fscr_lock_detect.sv
`default_nettype none
// ****************************************************************
// lock indicator: calibration done, delay countdown, tuning check
// ****************************************************************
module fscr_lock_detect
   import fscr_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic             cal_done_pin,
   input  wire logic             vtune_ok_pin,
   input  wire logic             pd_cycle_tick,
   input  wire logic             lock_kind,
   input  wire logic [CNT_W-1:0] lock_delay,
   output var  logic             lock_indicator
);

   if (CNT_W < 16) begin : g_chk
      $error("lock delay counter narrower than its field");
   end

   fscr_lock_state_t state;
   fscr_lock_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [1:0]       cal_meta;
   logic [1:0]       cal_sync;

   wire logic cal_s   = cal_sync[0];
   wire logic vtune_s = cal_sync[1];

   // both analog status levels cross in through two flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cal_meta <= '0;
         cal_sync <= '0;
      end else begin
         cal_meta <= {vtune_ok_pin, cal_done_pin};
         cal_sync <= cal_meta;
      end
   end

   // countdown in phase detector cycles once calibration is done
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         LD_WAIT_CAL: begin
            next_cnt = lock_delay;
            if (cal_s) begin
               next_state = (lock_delay == '0) ? LD_LOCKED : LD_COUNT;
            end
         end
         LD_COUNT: begin
            if (!cal_s) begin
               next_state = LD_WAIT_CAL;
            end else if (pd_cycle_tick) begin
               next_cnt = cnt - 1'b1;
               if (cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                  next_state = LD_LOCKED;
               end
            end
         end
         LD_LOCKED: begin
            if (!cal_s) begin
               next_state = LD_WAIT_CAL;
            end
         end
         default: next_state = LD_WAIT_CAL;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= LD_WAIT_CAL;
         cnt   <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // combined kind also needs the tuning voltage in range
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lock_indicator <= 1'b0;
      end else begin
         lock_indicator <= (state == LD_LOCKED) && cal_s &&
                           (!lock_kind || vtune_s);
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   cal_lock_need_a : assert property (
      lock_indicator |-> $past(state) == LD_LOCKED && $past(cal_s))
      else $error("lock shown without finished countdown");

   vtune_need_a : assert property (
      lock_indicator && $past(lock_kind) |-> $past(vtune_s))
      else $error("combined lock shown with tuning out of range");

   count_end_a : assert property (
      state == LD_COUNT && cal_s && pd_cycle_tick && cnt == 1
      |=> state == LD_LOCKED)
      else $error("countdown end did not reach lock");

   count_hold_a : assert property (
      state == LD_COUNT && cal_s && !pd_cycle_tick
      |=> state == LD_COUNT && $stable(cnt))
      else $error("countdown moved without a detector cycle");

   lock_reach_c : cover property (
      state == LD_COUNT ##[1:20] lock_indicator);

endmodule // fscr_lock_detect
`default_nettype wire

// >>> verif/tb_frac_synth_config_regs.sv
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_frac_synth_config_regs import fscr_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic           sys_clk = 0, resetn = 0, pd_cycle_tick = 1;
   logic           cal_done_pin = 0, vtune_ok_pin = 0;
   logic           sync_pin = 0, sysref_pin = 0;
   fscr_bus_req_t  bus_req = '0;
   logic [15:0]    rd_data;
   fscr_frac_cfg_t frac_cfg;
   fscr_out_cfg_t  out_a_cfg, out_b_cfg;
   logic [31:0]    frac_reset_delay_count;
   logic           phase_sync_enable, sync_out, sysref_out;
   logic           lock_indicator, irq;
   int             bad_count = 0, checks_done = 0;
   // offset, value after reset, writable bits (the rest reads zero)
   logic [38:0] tbl [12] = '{
      {7'h28, 16'h0000, 16'hFFFF}, {7'h29, 16'h0000, 16'hFFFF},
      {7'h2A, 16'h0000, 16'hFFFF}, {7'h2B, 16'h0000, 16'hFFFF},
      {7'h2C, 16'h1FA3, 16'h3FE7}, {7'h2D, 16'h001F, 16'h183F},
      {7'h2E, 16'h0001, 16'h0003}, {7'h3A, 16'h8000, 16'h8000},
      {7'h3B, 16'h0001, 16'h0001}, {7'h3C, 16'h09C4, 16'hFFFF},
      {7'h45, 16'h0000, 16'hFFFF}, {7'h46, 16'hC350, 16'hFFFF}};

   fscr_config_regs dut (.sys_clk, .resetn, .bus_req, .rd_data,
      .cal_done_pin, .vtune_ok_pin, .pd_cycle_tick, .sync_pin, .sysref_pin,
      .frac_cfg, .out_a_cfg, .out_b_cfg, .frac_reset_delay_count,
      .phase_sync_enable, .sync_out, .sysref_out, .lock_indicator, .irq);

   // free-running 20 MHz clock
   always #25 sys_clk = ~sys_clk;

   // ********************
   // bus cycles and waits
   // ********************
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      bus_req <= '0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge sys_clk);
      bus_req <= '0;
      #1 `CHK(rd_data, e)
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // n = 41 means no lock inside the bound
   task automatic wait_lock(input bit must, output int n);
      for (n = 1; n <= 40; n++) begin
         @(posedge sys_clk);
         #1;
         if (lock_indicator === 1'b1) break;
      end
      if (must && n > 40) begin
         bad_count++;
         complete_run();
      end
   endtask

   // ********************
   // scenarios
   // ********************
   task automatic t_regs();
      foreach (tbl[i]) begin
         rd(tbl[i][38:32], tbl[i][31:16]);
         wr(tbl[i][38:32], 16'hFFFF);
         rd(tbl[i][38:32], tbl[i][15:0]);
      end
      wr(7'h00, 16'hFFFF);
      rd(7'h00, 16'h0000);
   endtask
   task automatic t_fields();
      wr(ADDR_SEED_HI, 16'h1234);
      wr(ADDR_SEED_LO, 16'h5678);
      wr(ADDR_NUM_HI, 16'h9ABC);
      wr(ADDR_NUM_LO, 16'hDEF0);
      wr(ADDR_PWR_ENG, 16'h2A45);
      wr(ADDR_A_SRC_B, 16'h1815);
      wr(ADDR_B_SRC, 16'h0002);
      wr(ADDR_FRST_HI, 16'h0001);
      wr(ADDR_FRST_LO, 16'h0002);
      #1 `CHK(frac_cfg[67:64], 4'h5)
      `CHK(frac_cfg[63:0], 64'h12345678_9ABCDEF0)
      `CHK({out_a_cfg, out_b_cfg}, {9'h1EA, 9'h095})
      `CHK(frac_reset_delay_count, 32'h0001_0002)
   endtask
   // gated pins give no output and no event; ungated they set status bits and raise irq once enabled
   task automatic t_pins();
      {sync_pin, sysref_pin} <= 2'b11;
      cyc(6);
      `CHK({sync_out, sysref_out}, 2'b00)
      rd(ADDR_IRQ_STATUS, 16'h0000);
      {sync_pin, sysref_pin} <= 2'b00;
      cyc(4);
      wr(ADDR_SYNC_CTRL, 16'h0001);
      {sync_pin, sysref_pin} <= 2'b11;
      cyc(6);
      `CHK({phase_sync_enable, sync_out, sysref_out, irq}, 4'hE)
      rd(ADDR_IRQ_STATUS, 16'h000C);
      wr(ADDR_IRQ_ENABLE, 16'h0004);
      cyc(1);
      `CHK(irq, 1'b1)
      wr(ADDR_IRQ_CLEAR, 16'h000F);
      cyc(1);
      `CHK(irq, 1'b0)
      rd(ADDR_IRQ_STATUS, 16'h0000);
      // a sync rise in the very cycle of its clear must survive
      sync_pin <= 1'b0;
      cyc(4);
      sync_pin <= 1'b1;
      cyc(2);
      wr(ADDR_IRQ_CLEAR, 16'h0004);
      #1 `CHK(irq, 1'b1)
      wr(ADDR_IRQ_CLEAR, 16'h000F);
   endtask
   task automatic t_lock();
      int n;
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_LD_DELAY, wdata: 16'h0003};
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: ADDR_LD_DELAY, wdata: 16'h0000};
      @(posedge sys_clk);
      bus_req <= '0;
      #1 `CHK(rd_data, 16'h0003)
      cal_done_pin <= 1'b1;
      wait_lock(1'b0, n);
      `CHK(n, 41)
      vtune_ok_pin <= 1'b1;
      wait_lock(1'b1, n);
      rd(ADDR_IRQ_STATUS, 16'h0001);
      wr(ADDR_LD_KIND, 16'h0000);
      {cal_done_pin, vtune_ok_pin} <= 2'b00;
      cyc(5);
      `CHK(lock_indicator, 1'b0)
      {cal_done_pin, pd_cycle_tick} <= 2'b10;
      wait_lock(1'b0, n);
      `CHK(n, 41)
      pd_cycle_tick <= 1'b1;
      wait_lock(1'b1, n);
      `CHK(n, 4)
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // reset for five cycles, then the scenarios in turn
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      #1 `CHK(frac_cfg, {1'b1, 3'h3, 64'h0})
      `CHK({out_a_cfg, out_b_cfg}, {9'h01F, 9'h15F})
      `CHK({frac_reset_delay_count, irq}, 33'h0_0001_86A0)
      t_regs();
      t_fields();
      t_pins();
      t_lock();
      complete_run();
   end
endmodule // tb_frac_synth_config_regs
`default_nettype wire
